/* logic/tscd_device.sv */
/*
 Device end of the serial command decoder: samples the link on the system
 clock, decodes command bytes, shifts status and read data out, and issues
 register, payload and control strobes to the internal logic.
 Assumes register, FIFO and status sources answer combinationally on mclk_i.
*/
// Functional notes
// R1 - Select falling edge starts a new command
// R2 - Status shifts out during command byte
// R3 - Command is one byte, MSB first
// R4 - Byte order by bank and register; bits MSB-first
// R5 - Register read returns up to five bytes
// R6 - Register write only in power-down or standby
// R7 - Payload fetch from byte zero, then pop
// R8 - Payload load into transmit FIFO from zero
// R9 - Transmit purge empties transmit FIFO
// R10 - Receive purge empties receive FIFO; avoid during reply
// R11 - Repeat mode resends until load or purge
// R12 - Host never toggles repeat mid-transmission
// R13 - Activate 0x73 toggles three feature commands
// R14 - Inactive features: writes ignored, reads zero
// R15 - Activate 0x53 toggles bank; bank at bit7
// R16 - Host activates only in power-down or standby
// R17 - Length query returns head payload width
// R18 - Reply payload per pipe 0-5, receive mode
// R19 - No-reply payload load in transmit mode
// R20 - All-ones byte does nothing but status
// R21 - Repeat flag set by repeat, cleared by load or purge
// R22 - Writing one to irq bit clears it
// R23 - Select high abandons; excess bytes ignored
// R24 - Unknown commands ignored apart from status
`timescale 1ns/1ps
module tscd_device
	import tscd_pkg::*;
(
	// Clock and reset
	input  wire logic           mclk_i,
	input  wire logic           rst_n_i,
	// Serial link
	tscd_spi_if.dev             spi,
	// Mode inputs
	input  wire logic           standby_i,
	input  wire logic           prim_rx_i,
	input  wire logic [6:0]     status_i,
	// Register bank
	input  wire logic [4:0][7:0] reg_rdata_i,
	input  wire logic [2:0]     reg_width_i,
	output logic      [4:0]     reg_addr_o,
	output logic                reg_bank_o,
	output logic                reg_wr_o,
	output logic      [4:0][7:0] reg_wdata_o,
	output logic      [2:0]     reg_wbytes_o,
	output logic      [2:0]     irq_clr_o,
	// Payload FIFOs
	input  wire logic [7:0]     rx_byte_i,
	input  wire logic [5:0]     rx_len_i,
	output logic      [5:0]     rx_idx_o,
	output logic                rx_pop_o,
	output logic                rx_flush_o,
	output logic      [7:0]     tx_byte_o,
	output logic                tx_byte_valid_o,
	output tscd_tx_kind_t       tx_kind_o,
	output logic      [2:0]     tx_pipe_o,
	output logic                tx_commit_o,
	output logic                tx_flush_o,
	// Feature state
	output logic                repeat_active_o,
	output logic                features_on_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA} tscd_state_t;
	typedef enum logic [2:0] {OP_NONE, OP_RREG, OP_WREG, OP_RPL, OP_WPL, OP_RLEN, OP_ACT}
		tscd_op_t;

	tscd_state_t state;
	tscd_op_t    op;
	logic [2:0]  sck_s;
	logic [2:0]  sel_s;
	logic [1:0]  mosi_s;
	logic [2:0]  bit_cnt;
	logic [6:0]  sh_in;
	logic [6:0]  sh_out;
	logic [5:0]  byte_idx;

	// Byte position inside a register, honouring the byte order set by bank and register
	function automatic logic [2:0] byte_pos(input logic [5:0] k, input logic [2:0] w,
		input logic msb_first);
		byte_pos = msb_first ? 3'(w - 3'h1 - k[2:0]) : k[2:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Link sampling: two flops before any logic, third for edge detection
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sck_s  <= 3'h0;
			sel_s  <= 3'h7;
			mosi_s <= 2'h0;
		end else begin
			sck_s  <= {sck_s[1:0], spi.sck};
			sel_s  <= {sel_s[1:0], spi.sel_n};
			mosi_s <= {mosi_s[0], spi.mosi};
		end
	end

	wire sck_rise   = sck_s[1] & ~sck_s[2];
	wire sck_fall   = ~sck_s[1] & sck_s[2];
	wire sel_fall   = ~sel_s[1] & sel_s[2];
	wire sel_rise   = sel_s[1] & ~sel_s[2];
	wire active     = (state != ST_IDLE) && !sel_rise;
	wire byte_done  = active && sck_rise && (bit_cnt == 3'h7);
	wire [7:0] next_byte = {sh_in, mosi_s[1]};   // R3

	// Command decode, with feature and mode gating
	wire feat_ok    = features_on_o;
	wire is_rreg    = next_byte[7:5] == CMD_REG_RD_TOP;
	wire is_wreg    = next_byte[7:5] == CMD_REG_WR_TOP;
	wire is_reply   = (next_byte[7:3] == CMD_REPLY_TOP) && (next_byte[2:0] <= MAX_PIPE);
	wire cmd_now    = byte_done && (state == ST_CMD);
	wire data_now   = byte_done && (state == ST_DATA);

	// Register byte order and read data selection
	wire       msb_first = reg_bank_o && (reg_addr_o <= BANK1_MSB_LAST);   // R4
	wire       in_width  = byte_idx < {3'h0, reg_width_i};                 // R23
	wire [2:0] pos       = byte_pos(byte_idx, reg_width_i, msb_first);
	wire       shows_bank = !reg_bank_o && (reg_addr_o == STATUS_ADDR);
	wire [7:0] reg_sel   = reg_rdata_i[pos];
	wire [7:0] reg_byte  = (shows_bank && pos == 3'h0) ?
		{reg_bank_o, reg_sel[6:0]} : reg_sel;                               // R15
	wire [7:0] status_byte = {reg_bank_o, status_i};
	wire [7:0] out_byte =
		(op == OP_RREG) ? (in_width ? reg_byte : 8'h00) :                // R5
		(op == OP_RPL)  ? rx_byte_i :                                     // R7
		(op == OP_RLEN) ? {2'h0, rx_len_i} : 8'h00;                       // R17 R14

	////////////////////////////////////////////////////////////////////////////////
	// Transaction state and bit counting; select high drops partial bytes
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state   <= ST_IDLE;
			bit_cnt <= 3'h0;
			sh_in   <= 7'h00;
		end else if (sel_rise) begin
			state   <= ST_IDLE;                                           // R23
			bit_cnt <= 3'h0;
		end else if (sel_fall) begin
			state   <= ST_CMD;                                            // R1
			bit_cnt <= 3'h0;
		end else if (active && sck_rise) begin
			sh_in   <= next_byte[6:0];
			bit_cnt <= bit_cnt + 3'h1;
			if (cmd_now)
				state <= ST_DATA;
		end
	end

	// Decoded operation, latched when the command byte completes
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op <= OP_NONE;
		end else if (sel_fall) begin
			op <= OP_NONE;
		end else if (cmd_now) begin
			if (is_rreg)
				op <= OP_RREG;                                            // R5
			else if (is_wreg && standby_i)
				op <= OP_WREG;                                            // R6
			else if (next_byte == CMD_RX_FETCH)
				op <= OP_RPL;                                             // R7
			else if (next_byte == CMD_TX_LOAD)
				op <= OP_WPL;                                             // R8
			else if (feat_ok && is_reply && prim_rx_i)
				op <= OP_WPL;                                             // R18
			else if (feat_ok && next_byte == CMD_TX_NOREPLY && !prim_rx_i)
				op <= OP_WPL;                                             // R19
			else if (feat_ok && next_byte == CMD_RX_LEN)
				op <= OP_RLEN;                                            // R17
			else if (next_byte == CMD_ACTIVATE && standby_i)
				op <= OP_ACT;                                             // R16 R13
			else
				op <= OP_NONE;                                            // R24 R20 R14
		end
	end

	// Command fields and payload kind
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_addr_o <= 5'h00;
			tx_pipe_o  <= 3'h0;
			tx_kind_o  <= TX_KIND_NORMAL;
		end else if (cmd_now) begin
			reg_addr_o <= next_byte[4:0];
			tx_pipe_o  <= next_byte[2:0];
			tx_kind_o  <= is_reply ? TX_KIND_REPLY :
				(next_byte == CMD_TX_NOREPLY) ? TX_KIND_NOREPLY : TX_KIND_NORMAL;
		end
	end

	// Data byte index, saturating at the payload limit
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			byte_idx <= 6'h00;
		else if (cmd_now)
			byte_idx <= 6'h00;
		else if (data_now && byte_idx < PAYLOAD_MAX)
			byte_idx <= byte_idx + 6'h01;                                 // R23
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output shifter: status during the command byte, data afterwards
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			spi.miso    <= 1'h0;
			spi.miso_oe <= 1'h0;
			sh_out      <= 7'h00;
		end else if (sel_rise) begin
			spi.miso_oe <= 1'h0;
		end else if (sel_fall) begin
			spi.miso    <= status_byte[7];                               // R2
			spi.miso_oe <= 1'h1;
			sh_out      <= status_byte[6:0];
		end else if (active && sck_fall) begin
			if (bit_cnt == 3'h0 && state == ST_DATA) begin
				spi.miso <= out_byte[7];                                  // R4
				sh_out   <= out_byte[6:0];
			end else begin
				spi.miso <= sh_out[6];
				sh_out   <= {sh_out[5:0], 1'h0};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes gathered in order, committed when select rises
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_wdata_o  <= '0;
			reg_wr_o     <= 1'h0;
			reg_wbytes_o <= 3'h0;
			irq_clr_o    <= 3'h0;
		end else begin
			reg_wr_o  <= 1'h0;
			irq_clr_o <= 3'h0;
			if (data_now && op == OP_WREG && in_width)
				reg_wdata_o[pos] <= next_byte;                            // R4 R6
			if (sel_rise && state == ST_DATA && op == OP_WREG && byte_idx != 6'h00) begin
				reg_wr_o     <= 1'h1;
				reg_wbytes_o <= in_width ? byte_idx[2:0] : reg_width_i;   // R23
				if (shows_bank)
					irq_clr_o <= reg_wdata_o[0][IRQ_HI:IRQ_LO];           // R22
			end
		end
	end

	// Payload strobes toward the FIFOs
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_byte_o       <= 8'h00;
			tx_byte_valid_o <= 1'h0;
			tx_commit_o     <= 1'h0;
			rx_idx_o        <= 6'h00;
			rx_pop_o        <= 1'h0;
		end else begin
			tx_byte_valid_o <= 1'h0;
			tx_commit_o     <= 1'h0;
			rx_pop_o        <= 1'h0;
			if (data_now && op == OP_WPL && byte_idx < PAYLOAD_MAX) begin
				tx_byte_o       <= next_byte;                             // R8
				tx_byte_valid_o <= 1'h1;
			end
			if (cmd_now)
				rx_idx_o <= 6'h00;                                        // R7
			else if (data_now && op == OP_RPL && byte_idx < PAYLOAD_MAX)
				rx_idx_o <= byte_idx + 6'h01;
			if (sel_rise && state == ST_DATA && byte_idx != 6'h00) begin
				tx_commit_o <= op == OP_WPL;                              // R18
				rx_pop_o    <= op == OP_RPL;                              // R7
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Immediate commands: purges and repeat; activation toggles on its first data byte
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_flush_o      <= 1'h0;
			rx_flush_o      <= 1'h0;
			repeat_active_o <= 1'h0;
			features_on_o   <= 1'h0;
			reg_bank_o      <= 1'h0;
		end else begin
			tx_flush_o <= cmd_now && next_byte == CMD_TX_PURGE;           // R9
			rx_flush_o <= cmd_now && next_byte == CMD_RX_PURGE;           // R10
			// Cleared by load or purge; repeat only meaningful in transmit mode
			if (cmd_now && (next_byte == CMD_TX_LOAD || next_byte == CMD_TX_PURGE))
				repeat_active_o <= 1'h0;                                  // R21 R11
			else if (cmd_now && next_byte == CMD_REPEAT && !prim_rx_i)
				repeat_active_o <= 1'h1;                                  // R21 R11
			if (data_now && op == OP_ACT && byte_idx == 6'h00) begin
				if (next_byte == ACT_FEATURES)
					features_on_o <= !features_on_o;                      // R13
				if (next_byte == ACT_BANK)
					reg_bank_o <= !reg_bank_o;                            // R15
			end
		end
	end
endmodule

/* logic/tscd_host.sv */
/*
 Host end of the serial command link: sends one command byte and a number of
 data bytes, returns every byte read back, and makes the link clock itself.
 Assumes the user keeps cmd_i and nbytes_i steady while start_i is taken.
*/
`timescale 1ns/1ps
module tscd_host
	import tscd_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	// Serial link
	tscd_spi_if.host        spi,
	// Command request
	input  wire logic       start_i,
	input  wire logic [7:0] cmd_i,
	input  wire logic [5:0] nbytes_i,
	input  wire logic [7:0] wbyte_i,
	output logic            busy_o,
	output logic            wbyte_take_o,
	// Read back
	output logic      [7:0] rbyte_o,
	output logic            rbyte_valid_o,
	output logic            done_o
);
	typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} tscd_hstate_t;

	localparam logic [3:0] HALF_LAST = 4'(SCK_HALF_CYC - 1);
	localparam logic [3:0] GAP_LAST  = 4'(SEL_IDLE_CYC - 1);

	tscd_hstate_t state;
	logic [3:0]   tim;
	logic [1:0]   miso_s;
	logic [8:0]   bits_left;
	logic [2:0]   bit_cnt;
	logic [6:0]   tx_sh;
	logic [6:0]   rx_sh;

	wire half_end = tim == HALF_LAST;
	wire step     = (state == H_GAP) ? (tim == GAP_LAST) : half_end;
	wire [7:0] next_rx = {rx_sh, miso_s[1]};

	////////////////////////////////////////////////////////////////////////////////
	// Read line synchroniser and half-period timer
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			miso_s <= 2'h3;
			tim    <= 4'h0;
		end else begin
			miso_s <= {miso_s[0], spi.miso_line};
			tim    <= (state == H_IDLE || step) ? 4'h0 : tim + 4'h1;
		end
	end

	// Frame sequencer: select low, clock low half then high half, select high, gap
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state         <= H_IDLE;
			spi.sck       <= 1'h0;
			spi.sel_n     <= 1'h1;
			spi.mosi      <= 1'h0;
			busy_o        <= 1'h0;
			done_o        <= 1'h0;
			wbyte_take_o  <= 1'h0;
			rbyte_o       <= 8'h00;
			rbyte_valid_o <= 1'h0;
			bits_left     <= 9'h000;
			bit_cnt       <= 3'h0;
			tx_sh         <= 7'h00;
			rx_sh         <= 7'h00;
		end else begin
			done_o        <= 1'h0;
			wbyte_take_o  <= 1'h0;
			rbyte_valid_o <= 1'h0;
			unique case (state)
				H_IDLE: if (start_i) begin
					spi.sel_n <= 1'h0;                                    // R1
					spi.mosi  <= cmd_i[7];                                // R3
					tx_sh     <= cmd_i[6:0];
					bits_left <= {nbytes_i + 6'h01, 3'h0};
					bit_cnt   <= 3'h0;
					busy_o    <= 1'h1;
					state     <= H_LOW;
				end
				H_LOW: if (step) begin
					// Rising edge: capture the read line
					spi.sck   <= 1'h1;
					rx_sh     <= next_rx[6:0];
					bit_cnt   <= bit_cnt + 3'h1;
					bits_left <= bits_left - 9'h001;
					if (bit_cnt == 3'h7) begin
						rbyte_o       <= next_rx;
						rbyte_valid_o <= 1'h1;
					end
					state <= H_HIGH;
				end
				H_HIGH: if (step) begin
					spi.sck <= 1'h0;
					if (bits_left == 9'h000) begin
						state <= H_TAIL;
					end else begin
						if (bit_cnt == 3'h0) begin
							spi.mosi     <= wbyte_i[7];                   // R4
							tx_sh        <= wbyte_i[6:0];
							wbyte_take_o <= 1'h1;
						end else begin
							spi.mosi <= tx_sh[6];
							tx_sh    <= {tx_sh[5:0], 1'h0};
						end
						state <= H_LOW;
					end
				end
				H_TAIL: if (step) begin
					spi.sel_n <= 1'h1;
					state     <= H_GAP;
				end
				H_GAP: if (step) begin
					busy_o <= 1'h0;
					done_o <= 1'h1;
					state  <= H_IDLE;
				end
			endcase
		end
	end
endmodule

/* logic/tscd_pkg.sv */
/*
 Shared constants for the transceiver serial command decoder and its host end:
 command codes, field positions, byte limits and link timing.
 Assumes a 50 MHz system clock on both ends.
*/
package tscd_pkg;
	// System clock and link timing
	localparam int MCLK_MHZ      = 50;
	localparam int SCK_HALF_NS   = 160;
	localparam int SCK_HALF_CYC  = (SCK_HALF_NS * MCLK_MHZ) / 1000;
	localparam int SEL_IDLE_NS   = 50;
	localparam int SEL_IDLE_CYC  = (SEL_IDLE_NS * MCLK_MHZ + 999) / 1000;

	////////////////////////////////////////////////////////////////////////////////
	// Command words
	localparam logic [7:0] CMD_RX_FETCH   = 8'h61;
	localparam logic [7:0] CMD_TX_LOAD    = 8'ha0;
	localparam logic [7:0] CMD_TX_PURGE   = 8'he1;
	localparam logic [7:0] CMD_RX_PURGE   = 8'he2;
	localparam logic [7:0] CMD_REPEAT     = 8'he3;
	localparam logic [7:0] CMD_ACTIVATE   = 8'h50;
	localparam logic [7:0] CMD_RX_LEN     = 8'h60;
	localparam logic [7:0] CMD_TX_NOREPLY = 8'hb0;
	localparam logic [7:0] CMD_NOP        = 8'hff;
	localparam logic [2:0] CMD_REG_RD_TOP = 3'h0;
	localparam logic [2:0] CMD_REG_WR_TOP = 3'h1;
	localparam logic [4:0] CMD_REPLY_TOP  = 5'h15;

	// Activation data bytes
	localparam logic [7:0] ACT_FEATURES = 8'h73;
	localparam logic [7:0] ACT_BANK     = 8'h53;

	////////////////////////////////////////////////////////////////////////////////
	// Limits and register fields
	localparam logic [2:0] MAX_PIPE       = 3'h5;
	localparam logic [5:0] PAYLOAD_MAX    = 6'h20;
	localparam logic [4:0] BANK1_MSB_LAST = 5'h08;
	localparam logic [4:0] STATUS_ADDR    = 5'h07;
	localparam int         BANK_BIT       = 7;
	localparam int         IRQ_LO         = 4;
	localparam int         IRQ_HI         = 6;

	typedef enum logic [1:0] {TX_KIND_NORMAL, TX_KIND_NOREPLY, TX_KIND_REPLY} tscd_tx_kind_t;
endpackage

/* logic/tscd_spi_if.sv */
/*
 Serial link between the host end and the device end of the command decoder.
 Assumes the testbench instantiates it once and connects both modports.
*/
`timescale 1ns/1ps
interface tscd_spi_if;
	logic sck;
	logic sel_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic miso_line;

	// Released data line idles high
	assign miso_line = miso_oe ? miso : 1'h1;

	modport dev (input sck, input sel_n, input mosi, output miso, output miso_oe);
	modport host (output sck, output sel_n, output mosi, input miso_line);
endinterface

/* sim/tb.sv */
/*
 Testbench: host end and device end joined by the link interface; tests are
 command frames issued through the host's user side.
 Assumes the two design ends and the package compile first.
*/
`timescale 1ns/1ps
module tb;
	import tscd_pkg::*;
	logic            mclk_i = 0, rst_n_i = 0, start = 0, standby = 0, prim_rx = 0;
	logic      [7:0] cmd = 0, wbyte = 0, rx_byte = 0, rbyte_o, tx_byte_o;
	logic      [5:0] nb = 0, rx_idx_o;
	logic      [2:0] reg_width = 1, irq_clr_o, tx_pipe_o, reg_wbytes_o, wb;
	logic [4:0][7:0] reg_rdata = 0, reg_wdata_o, wd;
	logic      [4:0] reg_addr_o;
	logic     [39:0] ww;
	logic            busy_o, take_o, rvalid_o, done_o, reg_bank_o, reg_wr_o, pop_o, rfl_o;
	logic            tv_o, cm_o, tfl_o, rep_o, feat_o;
	tscd_tx_kind_t   kind_o;
	logic      [7:0] rq[$], tq[$];
	int              failures = 0, n_compared = 0, wi, n_wr, n_cm, n_tf, n_rf, n_pop;
	logic      [2:0] ic;

	always #10 mclk_i = ~mclk_i;

	tscd_spi_if spi_link();
	tscd_host tscd_host_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .spi(spi_link),
		.start_i(start), .cmd_i(cmd), .nbytes_i(nb), .wbyte_i(wbyte), .busy_o(busy_o),
		.wbyte_take_o(take_o), .rbyte_o(rbyte_o), .rbyte_valid_o(rvalid_o), .done_o(done_o));
	tscd_device tscd_device_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .spi(spi_link),
		.standby_i(standby), .prim_rx_i(prim_rx), .status_i(7'h2e), .reg_rdata_i(reg_rdata),
		.reg_width_i(reg_width), .reg_addr_o(reg_addr_o), .reg_bank_o(reg_bank_o),
		.reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o), .reg_wbytes_o(reg_wbytes_o),
		.irq_clr_o(irq_clr_o), .rx_byte_i(rx_byte), .rx_len_i(6'h1c), .rx_idx_o(rx_idx_o),
		.rx_pop_o(pop_o), .rx_flush_o(rfl_o), .tx_byte_o(tx_byte_o), .tx_byte_valid_o(tv_o),
		.tx_kind_o(kind_o), .tx_pipe_o(tx_pipe_o), .tx_commit_o(cm_o), .tx_flush_o(tfl_o),
		.repeat_active_o(rep_o), .features_on_o(feat_o));
	tscd_link_sva tscd_link_sva_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sck(spi_link.sck),
		.sel_n(spi_link.sel_n), .mosi(spi_link.mosi), .miso(spi_link.miso),
		.miso_oe(spi_link.miso_oe), .miso_line(spi_link.miso_line));

	////////////////////////////////////////////////////////////////////////////////
	// Register and receive store models, one cycle behind the address
	function automatic logic [7:0] lane(input int k, input logic [4:0] a);
		return 8'((8'h11 * (k + 1)) ^ {3'h0, a});
	endfunction
	always @(posedge mclk_i) begin
		for (int k = 0; k < 5; k++) reg_rdata[k] <= lane(k, reg_addr_o);
		reg_width <= (reg_addr_o == STATUS_ADDR) ? 3'h1 : 3'h5;
		rx_byte <= {2'h0, rx_idx_o} ^ 8'ha5;
	end

	// Collect read bytes, payload bytes and strobes of the current frame
	always @(posedge mclk_i) begin
		if (take_o === 1'b1) begin
			wi++;
			wbyte <= ww[8 * wi +: 8];
		end
		if (rvalid_o === 1'b1) rq.push_back(rbyte_o);
		if (tv_o === 1'b1) tq.push_back(tx_byte_o);
		if (reg_wr_o === 1'b1) begin
			n_wr++;
			wb = reg_wbytes_o;
			wd = reg_wdata_o;
		end
		if (irq_clr_o !== 3'h0) ic = irq_clr_o;
		n_cm += (cm_o === 1'b1);
		n_tf += (tfl_o === 1'b1);
		n_rf += (rfl_o === 1'b1);
		n_pop += (pop_o === 1'b1);
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One frame: command, data byte count, data bytes lowest first
	task automatic xfer(input logic [7:0] c, input logic [5:0] n, input logic [39:0] w);
		int k;
		rq.delete();
		tq.delete();
		{n_wr, n_cm, n_tf, n_rf, n_pop, wi} = '0;
		ic = 3'h0;
		ww = w;
		@(posedge mclk_i);
		start <= 1'b1;
		cmd <= c;
		nb <= n;
		wbyte <= w[7:0];
		@(posedge mclk_i);
		start <= 1'b0;
		for (k = 0; k < 6000 && done_o !== 1'b1; k++) @(posedge mclk_i);
		if (k == 6000) chk(8'h01, 8'h00);
		repeat (6) @(posedge mclk_i);
		$display("frame %h done", c);
	endtask

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// About 26 frames, none above 800 cycles; roughly three and a half times the expected run
	initial begin
		#600000;
		failures++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		repeat (2) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		xfer(CMD_NOP, 0, 0);
		chk(rq[0], 8'h2e);
		xfer({CMD_REG_RD_TOP, 5'h0a}, 5, 0);
		for (int k = 0; k < 5; k++) chk(rq[k + 1], lane(k, 5'h0a));
		chk({3'h0, reg_addr_o}, 8'h0a);
		chk({7'h0, busy_o}, 8'h00);
		xfer({CMD_REG_WR_TOP, 5'h0a}, 3, 40'h332211);
		chk(8'(n_wr), 8'h00);
		xfer(CMD_ACTIVATE, 1, ACT_BANK);
		chk({7'h0, reg_bank_o}, 8'h00);
		standby <= 1'b1;
		xfer({CMD_REG_WR_TOP, 5'h0a}, 3, 40'h332211);
		chk(8'(n_wr), 8'h01);
		chk({5'h0, wb}, 8'h03);
		for (int k = 0; k < 3; k++) chk(wd[k], 8'h11 * 8'(k + 1));
		xfer({CMD_REG_WR_TOP, STATUS_ADDR}, 3, 40'h000070);
		chk({5'h0, wb}, 8'h1);
		chk({5'h0, ic}, 8'h7);
		xfer(CMD_ACTIVATE, 1, ACT_BANK);
		chk({7'h0, reg_bank_o}, 8'h01);
		xfer(CMD_NOP, 0, 0);
		chk(rq[0], 8'hae);
		xfer({CMD_REG_RD_TOP, 5'h02}, 5, 0);
		for (int k = 0; k < 5; k++) chk(rq[k + 1], lane(4 - k, 5'h02));
		xfer(CMD_ACTIVATE, 1, ACT_BANK);
		xfer(CMD_RX_LEN, 1, 0);
		chk(rq[1], 8'h00);
		xfer(CMD_TX_NOREPLY, 1, 40'h77);
		chk(8'(tq.size() + n_cm), 8'h00);
		xfer(CMD_ACTIVATE, 1, ACT_FEATURES);
		chk({7'h0, feat_o}, 8'h1);
		xfer(CMD_RX_LEN, 1, 0);
		chk(rq[1], 8'h1c);
		xfer(CMD_TX_NOREPLY, 2, 40'hbbaa);
		chk(tq[1], 8'hbb);
		chk(8'(tq.size()), 8'h02);
		chk({6'h0, kind_o}, {6'h0, TX_KIND_NOREPLY});
		prim_rx <= 1'b1;
		xfer({CMD_REPLY_TOP, 3'h4}, 1, 40'h5a);
		chk({5'h0, tx_pipe_o}, 8'h04);
		chk({6'h0, kind_o}, {6'h0, TX_KIND_REPLY});
		chk(8'(n_cm), 8'h01);
		xfer({CMD_REPLY_TOP, 3'h6}, 1, 40'h5a);
		chk(8'(n_cm), 8'h00);
		xfer(CMD_RX_FETCH, 3, 0);
		for (int k = 0; k < 3; k++) chk(rq[k + 1], 8'(k) ^ 8'ha5);
		chk(8'(n_pop), 8'h01);
		xfer(CMD_RX_PURGE, 0, 0);
		chk(8'(n_rf), 8'h01);
		xfer(CMD_REPEAT, 0, 0);
		chk({7'h0, rep_o}, 8'h0);
		prim_rx <= 1'b0;
		xfer(CMD_REPEAT, 0, 0);
		chk({7'h0, rep_o}, 8'h1);
		xfer(CMD_TX_PURGE, 0, 0);
		chk(8'(n_tf), 8'h01);
		chk({7'h0, rep_o}, 8'h0);
		xfer(CMD_REPEAT, 0, 0);
		xfer(CMD_TX_LOAD, 2, 40'h0201);
		chk(tq[0], 8'h01);
		chk(8'(n_cm), 8'h01);
		chk({6'h0, kind_o}, {6'h0, TX_KIND_NORMAL});
		chk({7'h0, rep_o}, 8'h0);
		xfer(8'h70, 1, 40'h55);
		chk(rq[0], 8'h2e);
		chk(8'(n_wr + n_cm + n_tf + n_rf + n_pop + tq.size()), 8'h0);
		xfer(CMD_ACTIVATE, 1, ACT_FEATURES);
		chk({7'h0, feat_o}, 8'h0);
		end_of_test();
	end
endmodule

/* sim/tscd_link_sva.sv */
/*
 Link checker: watches the serial wires between host end and device end.
 Assumes mclk_i samples every wire and that the host makes the link clock.
*/
`timescale 1ns/1ps
module tscd_link_sva (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Link wires
	input wire logic sck,
	input wire logic sel_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic miso_line
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////////////////////
	// Framing and link clock shape
	property p_idle_sck; sel_n |-> !sck; endproperty
	a_idle_sck: assert property (p_idle_sck) else $error("sck moved outside a frame");
	property p_lead; $fell(sel_n) |-> !sck[*7]; endproperty
	a_lead: assert property (p_lead) else $error("sck rose too soon after select");
	property p_high; $rose(sck) |-> sck[*8] ##1 !sck; endproperty
	a_high: assert property (p_high) else $error("sck high phase length wrong");
	property p_low; $fell(sck) |-> !sck[*8]; endproperty
	a_low: assert property (p_low) else $error("sck low phase too short");
	property p_mosi; sck && $past(sck) |-> $stable(mosi); endproperty
	a_mosi: assert property (p_mosi) else $error("mosi moved while sck high");

	////////////////////////////////////////////////////////////////////////////////
	// Device data line: stable while sck high, driven soon after select falls, released within 6 cycles of select rising
	property p_miso; miso_oe && sck && $past(sck) |-> $stable(miso); endproperty
	a_miso: assert property (p_miso) else $error("miso moved while sck high");
	property p_line; !sel_n && sck && $past(sck) |-> $stable(miso_line); endproperty
	a_line: assert property (p_line) else $error("read line moved while sck high");
	property p_drive; $fell(sel_n) |-> ##[1:7] miso_oe; endproperty
	a_drive: assert property (p_drive) else $error("miso not driven in frame");
	property p_release; $rose(sel_n) |-> ##[1:6] !miso_oe; endproperty
	a_release: assert property (p_release) else $error("miso kept after frame");
	property p_oe_idle; sel_n && $past(sel_n, 6) |-> !miso_oe; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("miso driven while idle");
endmodule
